// ==== design/cpw_defs.svh ====
`ifndef CPW_DEFS_SVH
`define CPW_DEFS_SVH
`define CPW_INDEX_PORT 10'h3F0
`define CPW_DATA_PORT 10'h3F1
`define CPW_UNLOCK_KEY 8'h87
`define CPW_LOCK_KEY 8'hAA
`define CPW_IDX_LDN 8'h07
`define CPW_LDN_ACT 8'h07
`define CPW_LDN_TMO 8'h08
`define CPW_REG_ACT 8'h30
`define CPW_REG_TMO 8'hF2
`define CPW_CLK_HZ 25000000
`define CPW_HALF_MIN_S 30
`define CPW_FIRST_S 32
`define CPW_SW_CMD 4'h0
`define CPW_SW_STAT 4'h4
`define CPW_SW_IRQ 4'h8
`define CPW_SW_MASK 4'hC
`define CPW_SW_RDATA 4'h1
`define CPW_CMD_WRITE 2'h1
`define CPW_CMD_READ 2'h2
`endif

// ==== design/cpw_pkg.sv ====
package cpw_pkg;
  typedef enum logic [1:0] {CPW_LOCKED, CPW_HALF, CPW_OPEN} cpw_cfg_e;
  typedef enum logic [1:0] {CPW_H_IDLE, CPW_H_ADDR, CPW_H_DATA, CPW_H_DONE} cpw_host_e;
  typedef logic [7:0] cpw_byte_t;
endpackage : cpw_pkg

// ==== design/cpw_if.sv ====
interface cpw_if;
  logic [9:0] io_addr;
  logic [7:0] io_wdata;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_rdata;
  logic sys_reset_req;
  modport dev (input io_addr, input io_wdata, input io_wr, input io_rd, output io_rdata, output sys_reset_req);
  modport host (output io_addr, output io_wdata, output io_wr, output io_rd, input io_rdata, input sys_reset_req);
endinterface : cpw_if

// ==== design/cpw_device.sv ====
// Local design decision: the address-and-strobe port.
`include "cpw_defs.svh"
module cpw_device
  import cpw_pkg::*;
#(
  parameter int CLK_HZ = `CPW_CLK_HZ,
  parameter int HALF_MIN_S = `CPW_HALF_MIN_S,
  parameter int FIRST_S = `CPW_FIRST_S
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  cpw_if.dev bus
);
  // Cycle counts of the first period and of every later minute.
  localparam int SEC_CYC = CLK_HZ;
  localparam logic [31:0] FIRST_CYC = 32'(FIRST_S * SEC_CYC);
  localparam logic [31:0] MIN_CYC = 32'(2 * HALF_MIN_S * SEC_CYC);

  if (CLK_HZ < 1 || FIRST_S < 1 || HALF_MIN_S < 1)
  begin : bad_timing
    $error("cpw_device: timing parameters must be positive");
  end

  // The tick counter is 32 bits wide, so a longer period would wrap early.
  if (longint'(FIRST_S) * CLK_HZ > 64'hFFFFFFFF || longint'(2 * HALF_MIN_S) * CLK_HZ > 64'hFFFFFFFF)
  begin : bad_range
    $error("cpw_device: a period does not fit the tick counter");
  end

  cpw_cfg_e cfg_r;
  cpw_byte_t index_r;
  cpw_byte_t ldn_r;
  cpw_byte_t act_r;
  cpw_byte_t tmo_r;
  cpw_byte_t left_r;
  logic [31:0] tick_r;
  logic first_r;
  logic reload_r;
  logic rst_req_r;
  cpw_byte_t rdata_r;

  logic idx_wr;
  logic dat_wr;
  logic dat_rd;
  // Data-port accesses only count while the port is open.
  assign idx_wr = bus.io_wr && bus.io_addr == `CPW_INDEX_PORT;
  assign dat_wr = bus.io_wr && bus.io_addr == `CPW_DATA_PORT && cfg_r == CPW_OPEN;
  assign dat_rd = bus.io_rd && bus.io_addr == `CPW_DATA_PORT && cfg_r == CPW_OPEN;

  // True when the selected device and index name the given register.
  function automatic logic hit(input cpw_byte_t ldn, input cpw_byte_t idx, input cpw_byte_t want_ldn,
                               input cpw_byte_t want_idx);
    hit = ldn == want_ldn && idx == want_idx;
  endfunction : hit

  // Key sequence: two back-to-back 87h writes unlock; AAh relocks.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cfg_r <= CPW_LOCKED;
    else if (ce && idx_wr)
    begin
      case (cfg_r)
        CPW_LOCKED: cfg_r <= (bus.io_wdata == `CPW_UNLOCK_KEY) ? CPW_HALF : CPW_LOCKED;
        CPW_HALF: cfg_r <= (bus.io_wdata == `CPW_UNLOCK_KEY) ? CPW_OPEN : CPW_LOCKED;
        CPW_OPEN: cfg_r <= (bus.io_wdata == `CPW_LOCK_KEY) ? CPW_LOCKED : CPW_OPEN;
        default: cfg_r <= CPW_LOCKED;
      endcase
    end
  end

  // The lock key is not stored as an index, so a relock keeps the selection.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      index_r <= 8'h00;
    else if (ce && idx_wr && cfg_r == CPW_OPEN && bus.io_wdata != `CPW_LOCK_KEY)
      index_r <= bus.io_wdata;
  end

  // The device number is only taken through the selection index.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ldn_r <= 8'h00;
    else if (ce && dat_wr && index_r == `CPW_IDX_LDN)
      ldn_r <= bus.io_wdata;
  end

  // Only bit 0 of the activation register matters to the timer.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      act_r <= 8'h00;
    else if (ce && dat_wr && hit(ldn_r, index_r, `CPW_LDN_ACT, `CPW_REG_ACT))
      act_r <= bus.io_wdata;
  end

  // A zero time-out is stored but leaves the count where it stands.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tmo_r <= 8'h00;
      reload_r <= 1'b0;
    end
    else if (ce)
    begin
      reload_r <= 1'b0;
      if (dat_wr && hit(ldn_r, index_r, `CPW_LDN_TMO, `CPW_REG_TMO))
      begin
        tmo_r <= bus.io_wdata;
        reload_r <= bus.io_wdata != 8'h00;
      end
    end
  end

  // Unmapped registers and idle cycles read as zero.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata_r <= 8'h00;
    else if (ce)
    begin
      if (!dat_rd)
        rdata_r <= 8'h00;
      else if (index_r == `CPW_IDX_LDN)
        rdata_r <= ldn_r;
      else if (hit(ldn_r, index_r, `CPW_LDN_ACT, `CPW_REG_ACT))
        rdata_r <= act_r;
      else if (hit(ldn_r, index_r, `CPW_LDN_TMO, `CPW_REG_TMO))
        rdata_r <= tmo_r;
      else
        rdata_r <= 8'h00;
    end
  end

  // First period lasts 32 s, each later one a minute; n periods total.
  logic run;
  logic wrap;
  assign run = act_r[0] && tmo_r != 8'h00 && left_r != 8'h00;
  assign wrap = tick_r == (first_r ? FIRST_CYC : MIN_CYC) - 32'h1;

  // The tick restarts at every period boundary and on a reload.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      tick_r <= 32'h0;
    else if (ce)
    begin
      if (reload_r || (run && wrap))
        tick_r <= 32'h0;
      else if (run)
        tick_r <= tick_r + 32'h1;
    end
  end

  // Only the period right after a reload is the short one.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      first_r <= 1'b1;
    else if (ce)
    begin
      if (reload_r)
        first_r <= 1'b1;
      else if (run && wrap)
        first_r <= 1'b0;
    end
  end

  // Periods still to run before expiry.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      left_r <= 8'h00;
    else if (ce)
    begin
      if (reload_r)
        left_r <= tmo_r;
      else if (run && wrap)
        left_r <= left_r - 8'h01;
    end
  end

  // The request stands until a reload or a reset, so the host cannot miss it.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rst_req_r <= 1'b0;
    else if (ce)
    begin
      if (reload_r)
        rst_req_r <= 1'b0;
      else if (run && wrap && left_r == 8'h01)
        rst_req_r <= 1'b1;
    end
  end

  // Both outputs come straight from registers.
  assign bus.io_rdata = rdata_r;
  assign bus.sys_reset_req = rst_req_r;
endmodule : cpw_device

// ==== design/cpw_host.sv ====
`include "cpw_defs.svh"
module cpw_host
  import cpw_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [3:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  output logic irq,
  cpw_if.host bus
);
  // Command word: [7:0] data, [15:8] register, [23:16] logical device, [25:24] op.
  localparam int NSTEP = 7;
  cpw_host_e st_r;
  logic [2:0] step_r;
  logic [31:0] cmd_r;
  logic [7:0] rd_r;
  logic [1:0] stat_r;
  logic [1:0] mask_r;
  logic [31:0] sw_rdata_r;
  logic irq_r;
  logic [9:0] a_r;
  logic [7:0] d_r;
  logic wr_r;
  logic rd_o_r;
  logic done_ev;
  logic rst_ev;
  logic rst_seen_r;

  // Unlock twice, device select pair, register index, data, lock.
  function automatic logic [17:0] step_bus(input logic [2:0] s, input logic [31:0] c);
    case (s)
      3'd0: step_bus = {`CPW_INDEX_PORT, `CPW_UNLOCK_KEY};
      3'd1: step_bus = {`CPW_INDEX_PORT, `CPW_UNLOCK_KEY};
      3'd2: step_bus = {`CPW_INDEX_PORT, `CPW_IDX_LDN};
      3'd3: step_bus = {`CPW_DATA_PORT, c[23:16]};
      3'd4: step_bus = {`CPW_INDEX_PORT, c[15:8]};
      3'd5: step_bus = {`CPW_DATA_PORT, c[7:0]};
      default: step_bus = {`CPW_INDEX_PORT, `CPW_LOCK_KEY};
    endcase
  endfunction : step_bus

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_r <= CPW_H_IDLE;
      step_r <= 3'd0;
      cmd_r <= 32'h0;
      a_r <= 10'h000;
      d_r <= 8'h00;
      wr_r <= 1'b0;
      rd_o_r <= 1'b0;
      rd_r <= 8'h00;
    end
    else if (ce)
    begin
      wr_r <= 1'b0;
      rd_o_r <= 1'b0;
      case (st_r)
        CPW_H_IDLE:
          if (sw_wr && sw_addr == `CPW_SW_CMD && sw_wdata[25:24] != 2'h0)
          begin
            cmd_r <= sw_wdata;
            step_r <= 3'd0;
            st_r <= CPW_H_ADDR;
          end
        CPW_H_ADDR:
        begin
          {a_r, d_r} <= step_bus(step_r, cmd_r);
          if (step_r == 3'd5 && cmd_r[25:24] == `CPW_CMD_READ)
            rd_o_r <= 1'b1;
          else
            wr_r <= 1'b1;
          st_r <= CPW_H_DATA;
        end
        CPW_H_DATA:
        begin
          if (step_r == 3'd5 && cmd_r[25:24] == `CPW_CMD_READ)
            st_r <= CPW_H_DONE;
          else if (step_r == 3'(NSTEP - 1))
            st_r <= CPW_H_IDLE;
          else
          begin
            step_r <= step_r + 3'd1;
            st_r <= CPW_H_ADDR;
          end
        end
        CPW_H_DONE:
        begin
          rd_r <= bus.io_rdata;
          step_r <= 3'd6;
          st_r <= CPW_H_ADDR;
        end
        default: st_r <= CPW_H_IDLE;
      endcase
    end
  end

  assign done_ev = ce && st_r == CPW_H_DATA && step_r == 3'(NSTEP - 1);

  // The request comes from a register on this clock, so no synchroniser is needed.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rst_seen_r <= 1'b0;
    else if (ce)
      rst_seen_r <= bus.sys_reset_req;
  end

  assign rst_ev = bus.sys_reset_req && !rst_seen_r;

  // Set wins over write-one-to-clear.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      stat_r <= 2'h0;
    else if (ce)
      stat_r <= (stat_r & ~((sw_wr && sw_addr == `CPW_SW_IRQ) ? sw_wdata[1:0] : 2'h0)) | {rst_ev, done_ev};
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      mask_r <= 2'h0;
    else if (ce && sw_wr && sw_addr == `CPW_SW_MASK)
      mask_r <= sw_wdata[1:0];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irq_r <= 1'b0;
    else if (ce)
      irq_r <= |(stat_r & mask_r);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sw_rdata_r <= 32'h0;
    else if (ce)
    begin
      if (!sw_rd)
        sw_rdata_r <= 32'h0;
      else
        case (sw_addr)
          `CPW_SW_CMD: sw_rdata_r <= cmd_r;
          `CPW_SW_STAT: sw_rdata_r <= {22'h0, bus.sys_reset_req, st_r != CPW_H_IDLE, rd_r};
          `CPW_SW_IRQ: sw_rdata_r <= {30'h0, stat_r};
          `CPW_SW_MASK: sw_rdata_r <= {30'h0, mask_r};
          default: sw_rdata_r <= 32'h0;
        endcase
    end
  end

  assign sw_rdata = sw_rdata_r;
  assign irq = irq_r;
  assign bus.io_addr = a_r;
  assign bus.io_wdata = d_r;
  assign bus.io_wr = wr_r;
  assign bus.io_rd = rd_o_r;
endmodule : cpw_host

// ==== test/cpw_properties.sv ====
`include "cpw_defs.svh"
module cpw_properties #(
  parameter int CLK_HZ = 10,
  parameter int FIRST_S = 32
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [9:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_rdata,
  input wire logic sys_reset_req
);
  localparam int MIN_QUIET = FIRST_S * CLK_HZ - 4;
  int quiet_r;
  logic idx_wr;
  assign idx_wr = io_wr && io_addr == `CPW_INDEX_PORT;
  // Counts bus silence so an expiry cannot come early after the last write.
  always_ff @(posedge clk)
  begin
    if (!rst_n || io_wr)
    begin
      quiet_r <= 0;
    end
    else if (quiet_r < MIN_QUIET)
    begin
      quiet_r <= quiet_r + 1;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  one_strobe_a: assert property (!(io_wr && io_rd)) else $error("both strobes high");
  port_map_a: assert property ((io_wr || io_rd) |-> io_addr inside {`CPW_INDEX_PORT, `CPW_DATA_PORT})
    else $error("access outside the two ports");
  unlock_pair_a: assert property (idx_wr && io_wdata == `CPW_UNLOCK_KEY && $past(io_wdata, 2) != `CPW_UNLOCK_KEY
    |-> ##2 idx_wr && io_wdata == `CPW_UNLOCK_KEY) else $error("single unlock key");
  ldn_after_a: assert property (idx_wr && io_wdata == `CPW_UNLOCK_KEY && $past(idx_wr, 2)
    && $past(io_wdata, 2) == `CPW_UNLOCK_KEY |-> ##2 idx_wr && io_wdata == `CPW_IDX_LDN)
    else $error("no device select after unlock");
  ldn_data_a: assert property (idx_wr && io_wdata == `CPW_IDX_LDN |-> ##2 io_wr && io_addr == `CPW_DATA_PORT)
    else $error("device number missing");
  lock_after_a: assert property (io_wr && io_addr == `CPW_DATA_PORT && $past(io_wdata, 2) != `CPW_IDX_LDN
    |-> ##2 idx_wr && io_wdata == `CPW_LOCK_KEY) else $error("no lock after data");
  rdata_idle_a: assert property (!$past(io_rd) |-> io_rdata == 8'h00) else $error("read data without read");
  req_hold_a: assert property ($fell(sys_reset_req) |-> $past(io_wr) || $past(io_wr, 2))
    else $error("reset request dropped");
  expiry_gap_a: assert property ($rose(sys_reset_req) |-> quiet_r >= MIN_QUIET)
    else $error("expiry too early");
endmodule : cpw_properties

// ==== test/test_config_port_watchdog.sv ====
`include "cpw_defs.svh"
module test_config_port_watchdog;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HZ = 10;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [3:0] sw_addr = 4'h0;
  logic [31:0] sw_wdata = 32'h0;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [31:0] sw_rdata;
  logic irq;
  logic [31:0] st;
  int n;
  int err_total = 0;
  int num_checks = 0;
  cpw_if bus_if ();
  always #20 clk = ~clk;
  cpw_device #(.CLK_HZ(HZ)) cpw_device_i (.clk(clk), .rst_n(rst_n), .ce(ce), .bus(bus_if));
  cpw_host cpw_host_i (.clk(clk), .rst_n(rst_n), .ce(ce), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq), .bus(bus_if));
  cpw_properties #(.CLK_HZ(HZ)) cpw_properties_i (.clk(clk), .rst_n(rst_n), .io_addr(bus_if.io_addr),
    .io_wdata(bus_if.io_wdata), .io_wr(bus_if.io_wr), .io_rd(bus_if.io_rd), .io_rdata(bus_if.io_rdata),
    .sys_reset_req(bus_if.sys_reset_req));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic sw_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask : sw_write
  task automatic sw_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask : sw_read
  // Issues one configuration transfer and polls until the host is idle.
  task automatic cmd(input logic [1:0] op, input logic [7:0] ldn, input logic [7:0] rg, input logic [7:0] d);
    int k;
    k = 0;
    sw_write(`CPW_SW_CMD, {6'h00, op, ldn, rg, d});
    do
    begin
      sw_read(`CPW_SW_STAT, st);
      k++;
    end
    while (st[8] !== 1'b0 && k < 100);
    chk("busy", 32'h0, {31'h0, st[8]});
  endtask : cmd
  task automatic wait_req();
    n = 0;
    while (bus_if.sys_reset_req !== 1'b1 && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
  endtask : wait_req
  task automatic t_config();
    sw_write(`CPW_SW_MASK, 32'h3);
    cmd(`CPW_CMD_WRITE, `CPW_LDN_ACT, `CPW_REG_ACT, 8'h01);
    sw_read(`CPW_SW_IRQ, st);
    chk("done flag", 32'h1, st & 32'h1);
    chk("irq set", 32'h1, {31'h0, irq});
    sw_write(`CPW_SW_IRQ, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq clear", 32'h0, {31'h0, irq});
    cmd(`CPW_CMD_READ, `CPW_LDN_ACT, `CPW_REG_ACT, 8'h00);
    chk("activation", 32'h01, {24'h0, st[7:0]});
    sw_read(4'h2, st);
    chk("unmapped", 32'h0, st);
  endtask : t_config
  task automatic t_expire();
    cmd(`CPW_CMD_WRITE, `CPW_LDN_TMO, `CPW_REG_TMO, 8'h01);
    sw_write(`CPW_SW_IRQ, 32'h3);
    wait_req();
    chk("first expiry", 32'h1, {31'h0, n >= 300 && n <= 325});
    sw_read(`CPW_SW_IRQ, st);
    chk("req flag", 32'h2, st & 32'h2);
    cmd(`CPW_CMD_WRITE, `CPW_LDN_TMO, `CPW_REG_TMO, 8'h02);
    chk("req reload", 32'h0, {31'h0, bus_if.sys_reset_req});
    wait_req();
    chk("second expiry", 32'h1, {31'h0, n >= 900 && n <= 925});
  endtask : t_expire
  task automatic t_off();
    cmd(`CPW_CMD_WRITE, `CPW_LDN_ACT, `CPW_REG_ACT, 8'h00);
    cmd(`CPW_CMD_WRITE, `CPW_LDN_TMO, `CPW_REG_TMO, 8'h01);
    repeat (400) @(posedge clk);
    chk("inactive", 32'h0, {31'h0, bus_if.sys_reset_req});
    cmd(`CPW_CMD_WRITE, `CPW_LDN_ACT, `CPW_REG_ACT, 8'h01);
    @(posedge clk);
    ce <= 1'b0;
    repeat (400) @(posedge clk);
    chk("frozen", 32'h0, {31'h0, bus_if.sys_reset_req});
    ce <= 1'b1;
    cmd(`CPW_CMD_WRITE, `CPW_LDN_TMO, `CPW_REG_TMO, 8'h00);
    repeat (400) @(posedge clk);
    chk("disabled", 32'h0, {31'h0, bus_if.sys_reset_req});
  endtask : t_off
  initial
  begin
    #400000;
    err_total++;
    stop_test();
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_config();
    t_expire();
    t_off();
    stop_test();
  end
endmodule : test_config_port_watchdog
